/* dv/adcc_analog_model.sv */
// adcc_analog_model: analog inputs and comparator beside the converter control
// assumes the control answers i_trial with a hold of the sampled level
`timescale 1ns/100ps

module adcc_analog_model (
	// clock
	input  wire logic             i_clk,
	// from the control
	input  wire logic             i_sample,
	input  wire logic [3:0]       i_chan,
	input  wire logic [9:0]       i_trial,
	// pin levels
	input  wire logic [15:0][9:0] i_level,
	// comparator
	output logic                  o_above
);
	logic [9:0] held_r = 10'h000;

	// tracks the pin while sampling; hold phase freezes it, as a real cap would
	always_ff @(posedge i_clk) begin
		if (i_sample)
			held_r <= i_level[i_chan];
	end

	assign o_above = (held_r >= i_trial);
endmodule : adcc_analog_model

/* dv/test_sar_adc_conversion_control.sv */
// test_sar_adc_conversion_control: random and corner tests of adcc_ctrl
// assumes the analog model answers the comparator within the same cycle
`timescale 1ns/100ps
`include "adcc_params.svh"

module test_sar_adc_conversion_control;
	import adcc_pkg::*;
	localparam int STAB = 4;
	logic             i_clk;
	logic             i_rst;
	adcc_cpu_req_t    req;
	logic [15:0]      rdata;
	logic             wt;
	logic [3:0]       ch;
	logic             above;
	logic             smp;
	logic [9:0]       trial;
	logic [3:0]       chan;
	logic [15:0]      pins;
	logic             cmp_en;
	logic             irq;
	logic             susp;
	adcc_op_t         op;
	logic [15:0][9:0] level;
	logic [15:0]      got;
	logic             ws;
	logic [9:0]       v1;
	logic [9:0]       v2;
	logic [7:0]       m;
	logic             uc;
	logic             fast;
	int               fails;
	int               num_checks;
	int               cycles;
	int               n;
	int               t0;
	int               dv[8] = '{12, 8, 6, 4, 3, 2, 12, 12};

	adcc_ctrl #(.STAB_CYCLES(STAB)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_req(req),
		.o_rdata(rdata), .o_wait(wt), .i_chan_sel(ch), .i_cmp_above(above),
		.o_sample(smp), .o_trial_code(trial), .o_chan(chan), .o_pin_analog(pins),
		.o_cmp_enable(cmp_en), .o_irq(irq), .o_result_suspect(susp), .o_op(op));

	adcc_analog_model ana (.i_clk(i_clk), .i_sample(smp), .i_chan(chan),
		.i_trial(trial), .i_level(level), .o_above(above));

	////////////////////////////////////////////////////////////////////////////
	function automatic int period(input int i);
		return ((i % 2) ? 40 : 22) * dv[i / 2];
	endfunction : period

	task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_val

	task automatic chk_cnt(input int g, input int e);
		num_checks++;
		if (g != e) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_cnt

	// one access; two cycles so strobes never change twice in one step
	task automatic cpu(input logic [15:0] a, input logic w, input logic [7:0] d);
		req = '{addr: a, rd: !w, wr: w, wdata: d};
		@(posedge i_clk);
		#1;
		got = rdata;
		ws = wt;
		req.rd = 1'b0;
		req.wr = 1'b0;
		@(posedge i_clk);
		#1;
	endtask : cpu

	task automatic wait_irq();
		n = 0;
		do begin
			@(posedge i_clk);
			#1;
			n++;
		end while (irq !== 1'b1 && n < 2000);
	endtask : wait_irq

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			final_report();
		end
	end

	initial begin
		void'($urandom(32'h0261));
		fails = 0;
		num_checks = 0;
		cycles = 0;
		level = '0;
		ch = 4'h0;
		req = '0;
		i_rst = 1'b1;
		repeat (4) @(posedge i_clk);
		#1;
		i_rst = 1'b0;
		cpu(`ADCC_ADDR_MODE, 1'b0, 8'h00);
		chk_val(got, 16'h0000);
		chk_val(16'(op), 16'(ADCC_OP_STOP));
		cpu(`ADCC_ADDR_WORD, 1'b1, 8'hff);
		chk_val(16'(ws), 16'h0000);
		cpu(16'h1234, 1'b0, 8'h00);
		chk_val(got, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			m = 8'($urandom) & 8'h7f;
			m[0] = i[0];
			cpu(`ADCC_ADDR_MODE, 1'b1, m);
			chk_val(16'(ws), 16'h0001);
			chk_val(16'(cmp_en), 16'(m[0]));
			chk_val(16'(op), 16'(m[0] ? ADCC_OP_WAIT : ADCC_OP_STOP));
			cpu(`ADCC_ADDR_MODE, 1'b0, 8'h00);
			chk_val(got, {8'h00, m & 8'hbf});
		end
		$display("test mode done");
		for (int i = 0; i < 14; i++) begin
			uc = (i != 3);
			fast = (i == 5);
			ch = 4'($urandom);
			v1 = 10'($urandom);
			v2 = 10'($urandom);
			level[ch] = v1;
			m = {2'b00, 3'(i / 2), 1'b0, 1'(i % 2), uc};
			cpu(`ADCC_ADDR_MODE, 1'b1, 8'h00);
			if (uc) begin
				cpu(`ADCC_ADDR_MODE, 1'b1, m);
				// one case turns run on before the comparator has settled
				if (!fast) begin
					repeat (STAB + 2) @(posedge i_clk);
					#1;
				end
			end
			cpu(`ADCC_ADDR_MODE, 1'b1, m | 8'h80);
			chk_val(16'(op), 16'(uc ? ADCC_OP_CONV_CMP : ADCC_OP_CONV_NOCMP));
			chk_val(pins, 16'h0001 << ch);
			n = 0;
			while (smp !== 1'b0 && n < 1000) begin
				@(posedge i_clk);
				#1;
				n++;
			end
			level[ch] = ~v1;
			wait_irq();
			t0 = cycles;
			level[ch] = v2;
			chk_val(16'(susp), 16'(!uc || fast));
			chk_val(16'(chan), 16'(ch));
			@(posedge i_clk);
			#1;
			chk_val(16'(irq), 16'h0000);
			cpu(`ADCC_ADDR_WORD, 1'b0, 8'h00);
			chk_val(got, {v1, 6'h00});
			chk_val(16'(ws), 16'h0001);
			cpu(`ADCC_ADDR_HIGH, 1'b0, 8'h00);
			chk_val(got, {8'h00, v1[9:2]});
			wait_irq();
			chk_cnt(cycles - t0, period(i));
			chk_val(16'(susp), 16'h0000);
			cpu(`ADCC_ADDR_WORD, 1'b0, 8'h00);
			chk_val(got, {v2, 6'h00});
			cpu(`ADCC_ADDR_MODE, 1'b1, 8'h00);
			chk_val(16'(smp), 16'h0000);
			chk_val(16'(op), 16'(ADCC_OP_STOP));
			$display("test conversion %0d done", i);
		end
		n = 0;
		repeat (600) begin
			@(posedge i_clk);
			#1;
			if (irq === 1'b1)
				n++;
		end
		chk_cnt(n, 0);
		$display("test stopped done");
		final_report();
	end
endmodule : test_sar_adc_conversion_control

/* src/adcc_ctrl.sv */
// adcc_ctrl: successive-approximation conversion control with its registers
// assumes an external comparator answers the trial code within one tick
//
// Behaviour
// - repeat 10-bit conversions on the selected channel while enabled
// - raise the done request once per finished conversion
// - sixteen channels; unselected pins stay ordinary port pins
// - sample the input at start, hold it through the conversion
// - resolve from msb down to lsb, then move to result
// - word result: 10 bits high, lowest 6 bits read zero
// - byte result takes the upper 8 result bits
// - reading either result register inserts a wait cycle
// - writing the mode register inserts a wait cycle
// - mode register is 8 bits, resets to 00h, all stopped
// - bit 7 set runs conversion, cleared stops it
// - bit 0 enables the comparator; bit 6 stays zero
// - run and comparator bits decode into four operating states
// - first result valid only if run followed comparator by 1 us
// - conversion time comes from speed bits 5..3 and range bit 1
// - upper 8 bits in high byte, lowest 2 in low byte bits 7..6
`timescale 1ns/100ps
`include "adcc_params.svh"

module adcc_ctrl #(
	parameter int unsigned STAB_CYCLES = `ADCC_STAB_CYC
) (
	// clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// cpu access
	input  wire adcc_pkg::adcc_cpu_req_t i_req,
	output logic [15:0]                 o_rdata,
	output logic                        o_wait,
	// analog front end
	input  wire logic [3:0]             i_chan_sel,
	input  wire logic                   i_cmp_above,
	output logic                        o_sample,
	output logic [9:0]                  o_trial_code,
	output logic [3:0]                  o_chan,
	output logic [15:0]                 o_pin_analog,
	output logic                        o_cmp_enable,
	// status
	output logic                        o_irq,
	output logic                        o_result_suspect,
	output adcc_pkg::adcc_op_t          o_op
);
	import adcc_pkg::*;

	typedef struct packed {
		adcc_mode_t  mode;
		adcc_op_t    op;
		adcc_state_t st;
		logic [9:0]  sar;
		logic [3:0]  bit_idx;
		logic [5:0]  ticks;
		logic [15:0] word;
		logic [7:0]  high;
		logic [15:0] rdata;
		logic        wait_cyc;
		logic        irq;
		logic [6:0]  stab_cnt;
		logic        first_pend;
		logic        first_bad;
		logic        suspect;
		logic [3:0]  chan;
		logic [15:0] pin_mask;
		logic        sample;
	} adcc_ctrl_st_t;

	localparam logic [6:0] STAB = 7'(STAB_CYCLES);

	adcc_ctrl_st_t s_r;
	adcc_ctrl_st_t s_nxt;
	logic          tick;
	logic [5:0]    samp_last;
	logic          stab_done;
	logic          res_rd;
	logic          mode_wr;

	// both result registers answer with a wait cycle; the mode register on writes
	function automatic logic adcc_is_result(input logic [15:0] addr);
		return (addr == `ADCC_ADDR_WORD) || (addr == `ADCC_ADDR_HIGH);
	endfunction : adcc_is_result

	assign res_rd  = i_req.rd && adcc_is_result(i_req.addr);
	assign mode_wr = i_req.wr && (i_req.addr == `ADCC_ADDR_MODE);

	////////////////////////////////////////////////////////////////////////////
	// conversion clock; held in reset while idle so each start is aligned

	adcc_tick_div u_div (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_run   (s_r.st != ADCC_ST_IDLE),
		.i_speed (s_r.mode.speed),
		.o_tick  (tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [9:0] res;
		res = s_r.sar;
		s_nxt = s_r;
		s_nxt.irq = 1'b0;
		s_nxt.wait_cyc = 1'b0;
		stab_done = (s_r.stab_cnt >= STAB);
		// low-voltage range trades a longer sampling window for accuracy
		samp_last = (s_r.mode.range[0] ? `ADCC_SAMPLE_TICKS_L : `ADCC_SAMPLE_TICKS_N)
			- 6'h01;

		// comparator settling time since the enable went high
		if (!s_r.mode.cmp_on) begin
			s_nxt.stab_cnt = 7'h00;
		end else if (!stab_done) begin
			s_nxt.stab_cnt = s_r.stab_cnt + 7'h01;
		end

		// register reads
		if (i_req.rd) begin
			s_nxt.wait_cyc = res_rd;
			if (i_req.addr == `ADCC_ADDR_MODE) begin
				s_nxt.rdata = {8'h00, s_r.mode};
			end else if (i_req.addr == `ADCC_ADDR_WORD) begin
				s_nxt.rdata = s_r.word;
			end else if (i_req.addr == `ADCC_ADDR_HIGH) begin
				s_nxt.rdata = {8'h00, s_r.high};
			end else begin
				s_nxt.rdata = 16'h0000;
			end
		end

		// conversion sequence
		unique case (s_r.st)
			ADCC_ST_IDLE: begin
				if (s_r.mode.run) begin
					s_nxt.st = ADCC_ST_SAMPLE;
					s_nxt.ticks = 6'h00;
					s_nxt.chan = i_chan_sel;
					s_nxt.sample = 1'b1;
				end
			end
			ADCC_ST_SAMPLE: begin
				if (tick) begin
					if (s_r.ticks == samp_last) begin
						s_nxt.st = ADCC_ST_CONVERT;
						s_nxt.sample = 1'b0;
						s_nxt.sar = `ADCC_RES_MSB_TRIAL;
						s_nxt.bit_idx = 4'h9;
					end else begin
						s_nxt.ticks = s_r.ticks + 6'h01;
					end
				end
			end
			ADCC_ST_CONVERT: begin
				if (tick) begin
					if (!i_cmp_above) begin
						res[s_r.bit_idx] = 1'b0;
					end
					if (s_r.bit_idx == 4'h0) begin
						s_nxt.sar = res;
						s_nxt.word = {res, `ADCC_WORD_PAD};
						s_nxt.high = res[9:2];
						s_nxt.irq = 1'b1;
						// software must drop a flagged first result
						s_nxt.suspect = s_r.first_pend && s_r.first_bad;
						s_nxt.first_pend = 1'b0;
						s_nxt.st = ADCC_ST_SAMPLE;
						s_nxt.ticks = 6'h00;
						s_nxt.chan = i_chan_sel;
						s_nxt.sample = 1'b1;
					end else begin
						res[s_r.bit_idx - 4'h1] = 1'b1;
						s_nxt.sar = res;
						s_nxt.bit_idx = s_r.bit_idx - 4'h1;
					end
				end
			end
			// code 3 cannot arise; return to idle rather than hang
			default: s_nxt.st = ADCC_ST_IDLE;
		endcase

		// mode write; a write during a conversion's last tick still keeps that result
		if (mode_wr) begin
			s_nxt.wait_cyc = 1'b1;
			s_nxt.mode = i_req.wdata;
			s_nxt.mode.zero = 1'b0;
			if (i_req.wdata[`ADCC_MODE_RUN] && !s_r.mode.run) begin
				s_nxt.first_pend = 1'b1;
				s_nxt.first_bad = !(i_req.wdata[`ADCC_MODE_CMP]
					&& s_r.mode.cmp_on && stab_done);
			end
		end

		// stop aborts whatever is in flight
		if (!s_nxt.mode.run) begin
			s_nxt.st = ADCC_ST_IDLE;
			s_nxt.sample = 1'b0;
		end

		unique case ({s_nxt.mode.run, s_nxt.mode.cmp_on})
			2'b00: s_nxt.op = ADCC_OP_STOP;
			2'b01: s_nxt.op = ADCC_OP_WAIT;
			2'b10: s_nxt.op = ADCC_OP_CONV_NOCMP;
			2'b11: s_nxt.op = ADCC_OP_CONV_CMP;
		endcase

		// only the active channel is taken from the port logic
		s_nxt.pin_mask = (s_nxt.st != ADCC_ST_IDLE)
			? (16'h0001 << s_nxt.chan) : 16'h0000;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_rdata          = s_r.rdata;
	assign o_wait           = s_r.wait_cyc;
	assign o_sample         = s_r.sample;
	assign o_trial_code     = s_r.sar;
	assign o_chan           = s_r.chan;
	assign o_pin_analog     = s_r.pin_mask;
	assign o_cmp_enable     = s_r.mode.cmp_on;
	assign o_irq            = s_r.irq;
	assign o_result_suspect = s_r.suspect;
	assign o_op             = s_r.op;

	////////////////////////////////////////////////////////////////////////////
	// checks

	chk_mode_reset_zero: assert property (@(posedge i_clk)
		i_rst |=> (s_r.mode == `ADCC_MODE_RESET) && (o_op == ADCC_OP_STOP))
		else $error("mode not cleared after reset");

	chk_mode_bit_six: assert property (@(posedge i_clk) disable iff (i_rst)
		s_r.mode.zero == 1'b0)
		else $error("mode bit 6 not zero");

	chk_read_wait: assert property (@(posedge i_clk) disable iff (i_rst)
		res_rd |=> o_wait)
		else $error("result read without wait cycle");

	chk_write_wait: assert property (@(posedge i_clk) disable iff (i_rst)
		mode_wr |=> o_wait ##1 (!o_wait || $past(res_rd || mode_wr)))
		else $error("mode write wait missing or too long");

	chk_irq_one_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
		o_irq |=> !o_irq)
		else $error("done request longer than one cycle");

	chk_result_layout: assert property (@(posedge i_clk) disable iff (i_rst)
		o_irq |-> (s_r.word[5:0] == 6'h00) && (s_r.word[15:8] == s_r.high)
			&& (s_r.word[15:6] == s_r.sar))
		else $error("result registers inconsistent at completion");

	chk_msb_first: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_r.st == ADCC_ST_CONVERT) && ($past(s_r.st) == ADCC_ST_SAMPLE)
		|-> (s_r.sar == `ADCC_RES_MSB_TRIAL) && (s_r.bit_idx == 4'h9))
		else $error("conversion did not start at msb");

	chk_hold_chan: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_r.st == ADCC_ST_CONVERT) |-> !o_sample && $stable(o_chan))
		else $error("input not held during conversion");

	chk_repeat_conv: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_irq && s_r.mode.run) |-> (s_r.st == ADCC_ST_SAMPLE) && o_sample)
		else $error("conversion did not restart");

	chk_stop_idle: assert property (@(posedge i_clk) disable iff (i_rst)
		!s_r.mode.run |-> (s_r.st == ADCC_ST_IDLE) && !o_sample && (o_pin_analog == 16'h0000))
		else $error("conversion running while stopped");

	chk_op_decode: assert property (@(posedge i_clk) disable iff (i_rst)
		o_op == adcc_op_t'({s_r.mode.run, s_r.mode.cmp_on}))
		else $error("operating state does not match mode bits");

	chk_first_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_req.wr && (i_req.addr == `ADCC_ADDR_MODE) && i_req.wdata[`ADCC_MODE_RUN]
			&& !s_r.mode.run && !s_r.mode.cmp_on) |=> s_r.first_pend && s_r.first_bad)
		else $error("first result not flagged without settled comparator");

	// access, result and sequence checks
	chk_wait_source: assert property (@(posedge i_clk) disable iff (i_rst)
		o_wait |-> $past(res_rd || mode_wr))
		else $error("wait cycle without a register access");

	chk_cmp_follow: assert property (@(posedge i_clk) disable iff (i_rst)
		mode_wr |=> (o_cmp_enable == $past(i_req.wdata[`ADCC_MODE_CMP])))
		else $error("comparator enable does not follow mode write");

	chk_run_start: assert property (@(posedge i_clk) disable iff (i_rst)
		(mode_wr && i_req.wdata[`ADCC_MODE_RUN] && !s_r.mode.run) |=> ##1 (o_sample || !s_r.mode.run))
		else $error("conversion did not start after run was set");

	chk_done_source: assert property (@(posedge i_clk) disable iff (i_rst)
		o_irq |-> ($past(s_r.st) == ADCC_ST_CONVERT) && ($past(s_r.bit_idx) == 4'h0)
			&& $past(tick))
		else $error("done request without a finished conversion");

	chk_result_stable: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_irq |-> $stable(s_r.word) && $stable(s_r.high))
		else $error("result registers changed between completions");

	chk_pin_onehot: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_r.st != ADCC_ST_IDLE) |-> $onehot(o_pin_analog) && o_pin_analog[o_chan])
		else $error("analog pin select does not match channel");

	chk_chan_latch: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_sample) |-> (o_chan == $past(i_chan_sel)))
		else $error("channel not latched at conversion start");

	chk_trial_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		((s_r.st == ADCC_ST_CONVERT) && !tick) |=> $stable(o_trial_code))
		else $error("trial code moved between conversion ticks");

	chk_bit_step: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_r.st == ADCC_ST_CONVERT) && tick && (s_r.bit_idx != 4'h0)
		|=> (s_r.bit_idx == $past(s_r.bit_idx) - 4'h1))
		else $error("approximation did not step one bit down");

	chk_sample_length: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_r.st == ADCC_ST_CONVERT) && ($past(s_r.st) == ADCC_ST_SAMPLE)
		|-> (s_r.ticks == (($past(s_r.mode.range[0]) ? `ADCC_SAMPLE_TICKS_L : `ADCC_SAMPLE_TICKS_N) - 6'h01)))
		else $error("sampling phase length does not follow range");

	chk_suspect_timing: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(o_result_suspect) |-> o_irq)
		else $error("first-result flag moved outside a completion");

	chk_settle_clear: assert property (@(posedge i_clk) disable iff (i_rst)
		!s_r.mode.cmp_on |=> (s_r.stab_cnt == 7'h00))
		else $error("comparator settling count kept while disabled");

endmodule : adcc_ctrl

/* src/adcc_params.svh */
// adcc_params.svh: addresses, field positions, reset values and timing counts
// assumes a 100 MHz peripheral clock with a 10 ns period
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// cpu-visible addresses
`define ADCC_ADDR_MODE      16'hff2a
`define ADCC_ADDR_WORD      16'hff18
`define ADCC_ADDR_HIGH      16'hff19

// mode register fields
`define ADCC_MODE_RUN       7
`define ADCC_MODE_ZERO      6
`define ADCC_MODE_CMP       0
`define ADCC_MODE_RESET     8'h00

// result layout
`define ADCC_RES_W          10
`define ADCC_RES_MSB_TRIAL  10'h200
`define ADCC_WORD_PAD       6'h00

// timing
`define ADCC_CLK_NS         10
`define ADCC_STAB_NS        1000
`define ADCC_STAB_CYC       ((`ADCC_STAB_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_SAMPLE_TICKS_N 6'h0c
`define ADCC_SAMPLE_TICKS_L 6'h1e

// conversion clock divisors per speed code
`define ADCC_DIV_0          4'hc
`define ADCC_DIV_1          4'h8
`define ADCC_DIV_2          4'h6
`define ADCC_DIV_3          4'h4
`define ADCC_DIV_4          4'h3
`define ADCC_DIV_5          4'h2

`endif

/* src/adcc_pkg.sv */
// adcc_pkg: types and shared decode for the converter control
// assumes adcc_params.svh is on the include path
`include "adcc_params.svh"

package adcc_pkg;

	typedef struct packed {
		logic       run;
		logic       zero;
		logic [2:0] speed;
		logic [1:0] range;
		logic       cmp_on;
	} adcc_mode_t;

	typedef enum logic [1:0] {
		ADCC_OP_STOP,
		ADCC_OP_WAIT,
		ADCC_OP_CONV_NOCMP,
		ADCC_OP_CONV_CMP
	} adcc_op_t;

	typedef enum logic [1:0] {
		ADCC_ST_IDLE,
		ADCC_ST_SAMPLE,
		ADCC_ST_CONVERT
	} adcc_state_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} adcc_cpu_req_t;

	// prohibited speed codes fall back to the slowest clock
	function automatic logic [3:0] adcc_divisor(input logic [2:0] speed);
		logic [3:0] d;
		d = `ADCC_DIV_0;
		case (speed)
			3'h1: d = `ADCC_DIV_1;
			3'h2: d = `ADCC_DIV_2;
			3'h3: d = `ADCC_DIV_3;
			3'h4: d = `ADCC_DIV_4;
			3'h5: d = `ADCC_DIV_5;
			default: d = `ADCC_DIV_0;
		endcase
		return d;
	endfunction : adcc_divisor

endpackage : adcc_pkg

/* src/adcc_tick_div.sv */
// adcc_tick_div: conversion clock enable from the peripheral clock
// assumes i_speed is only changed while i_run is low
`timescale 1ns/100ps

module adcc_tick_div (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// control
	input  wire logic       i_run,
	input  wire logic [2:0] i_speed,
	// enable out
	output logic            o_tick
);
	import adcc_pkg::*;

	typedef struct packed {
		logic [3:0] cnt;
		logic       tick;
	} adcc_div_st_t;

	adcc_div_st_t s_r;
	adcc_div_st_t s_nxt;
	logic [3:0]   div;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		div = adcc_divisor(i_speed);
		s_nxt.tick = 1'b0;
		if (!i_run) begin
			s_nxt.cnt = 4'h0;
		end else if (s_r.cnt == div - 4'h1) begin
			s_nxt.cnt = 4'h0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 4'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_tick = s_r.tick;

	////////////////////////////////////////////////////////////////////////////
	chk_tick_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
		o_tick |=> !o_tick)
		else $error("conversion tick on two adjacent cycles");

endmodule : adcc_tick_div
